// ### svfm_consts.vh
// Constants for the unknown-VID forwarding and MAC frame control block
// Contract
// - When the unknown-VID forward enable is set, frames with an unknown VLAN ID go to the selected ports, else not.
// - Three select bits pick the ports for unknown-VID frames: bit 2 port 3, bit 1 port 2, bit 0 port 1.
// - The alternate back-off bit (MAC control bit 7) acts only on ports running half-duplex.
// - With length check set, a frame whose type/length field is below 1500 and differs from its real length is dropped.
// - With flow-control drop mode set, a frame with type 0x8808 or DA 01-80-C2-00-00-01 is dropped.
// - With flow-control drop mode clear, a frame is dropped only when it has both type 0x8808 and the pause DA.
// - With aggressive back-off set, a non-standard aggressive back-off is used in half-duplex with back pressure.
// - A frame that is unknown in several ways is handled as unknown VID first, then unknown unicast, then multicast.
// - With no-excessive-collision-drop set, frames seeing 16 or more collisions are kept, otherwise dropped.
`ifndef SVFM_CONSTS_VH
`define SVFM_CONSTS_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define SVFM_ADDR_W 12
`define SVFM_OFF_UVID 12'h328
`define SVFM_OFF_MAC0 12'h330
`define SVFM_OFF_MAC1 12'h334
`define SVFM_OFF_STAT 12'h338
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SVFM_UVID_EN 31
`define SVFM_UVID_MASK 32'h8000_0007
`define SVFM_UVID_RESET 32'h0000_0000
`define SVFM_MAC0_ALT_BO 7
`define SVFM_MAC0_LEN_CHK 3
`define SVFM_MAC0_FC_MODE 1
`define SVFM_MAC0_AGG_BO 0
`define SVFM_MAC0_RESET 8'h0e
`define SVFM_MAC1_NO_XCOL 0
`define SVFM_MAC1_RESET 8'h00
// ----------------------------------------
// Frame constants
// ----------------------------------------
`define SVFM_LEN_LIMIT 16'h05dc
`define SVFM_TYPE_FC 16'h8808
`define SVFM_DA_PAUSE 48'h0180c2000001
`define SVFM_XCOL_LIMIT 5'h10
`define SVFM_NPORT 3
`endif

// ### svfm_vlan_table.v
// VLAN membership table with valid bit per entry
`timescale 1ns/1ps
`include "svfm_consts.vh"
module svfm_vlan_table #(
  parameter VID_W = 12
) (
  ref_clk,
  reset,
  wr_en,
  wr_vid,
  wr_valid,
  wr_ports,
  rd_vid,
  rd_hit,
  rd_ports
);
  input wire ref_clk;
  input wire reset;
  input wire wr_en;
  input wire [VID_W-1:0] wr_vid;
  input wire wr_valid;
  input wire [`SVFM_NPORT-1:0] wr_ports;
  input wire [VID_W-1:0] rd_vid;
  output wire rd_hit;
  output wire [`SVFM_NPORT-1:0] rd_ports;

  reg [(1<<VID_W)-1:0] valid_reg;
  reg [`SVFM_NPORT-1:0] ports_mem [0:(1<<VID_W)-1];

  always @(posedge ref_clk) begin
    if (reset) begin
      valid_reg <= {(1<<VID_W){1'b0}};
    end else if (wr_en) begin
      valid_reg[wr_vid] <= wr_valid;
    end
  end

  always @(posedge ref_clk) begin
    if (wr_en) begin
      ports_mem[wr_vid] <= wr_ports;
    end
  end

  // Combinational lookup so classification sees the table in the same cycle
  assign rd_hit = valid_reg[rd_vid];
  assign rd_ports = ports_mem[rd_vid];
endmodule // svfm_vlan_table

// ### svfm_fwd_mac_ctrl.v
// Unknown-VID forwarding, frame drop filtering and back-off control
`timescale 1ns/1ps
`include "svfm_consts.vh"
module svfm_fwd_mac_ctrl #(
  parameter VID_W = 12
) (
  ref_clk,
  reset,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  vt_wr_en,
  vt_wr_vid,
  vt_wr_valid,
  vt_wr_ports,
  frm_valid,
  frm_vid,
  frm_da,
  frm_type_len,
  frm_payload_len,
  frm_uucast,
  frm_umcast,
  uucast_ports,
  umcast_ports,
  port_half_duplex,
  col_event,
  col_count,
  dec_valid,
  dec_drop,
  dec_ports,
  dec_class,
  alt_backoff_en,
  agg_backoff_en,
  col_drop
);
  input wire ref_clk;
  input wire reset;
  input wire [`SVFM_ADDR_W-1:0] reg_addr;
  input wire [31:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [31:0] reg_rdata;
  input wire vt_wr_en;
  input wire [VID_W-1:0] vt_wr_vid;
  input wire vt_wr_valid;
  input wire [`SVFM_NPORT-1:0] vt_wr_ports;
  input wire frm_valid;
  input wire [VID_W-1:0] frm_vid;
  input wire [47:0] frm_da;
  input wire [15:0] frm_type_len;
  input wire [15:0] frm_payload_len;
  input wire frm_uucast;
  input wire frm_umcast;
  input wire [`SVFM_NPORT-1:0] uucast_ports;
  input wire [`SVFM_NPORT-1:0] umcast_ports;
  input wire [`SVFM_NPORT-1:0] port_half_duplex;
  input wire [`SVFM_NPORT-1:0] col_event;
  input wire [4:0] col_count;
  output reg dec_valid;
  output reg dec_drop;
  output reg [`SVFM_NPORT-1:0] dec_ports;
  output reg [1:0] dec_class;
  output reg [`SVFM_NPORT-1:0] alt_backoff_en;
  output reg [`SVFM_NPORT-1:0] agg_backoff_en;
  output reg [`SVFM_NPORT-1:0] col_drop;

  // ----------------------------------------
  // Frame classes as reported on dec_class
  // ----------------------------------------
  localparam CLS_KNOWN = 2'h0;
  localparam CLS_UVID = 2'h1;
  localparam CLS_UUC = 2'h2;
  localparam CLS_UMC = 2'h3;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [31:0] uvid_reg;
  reg [7:0] mac0_reg;
  reg [7:0] mac1_reg;
  reg [15:0] drop_cnt_reg;
  reg [15:0] uvid_cnt_reg;

  wire vt_hit;
  wire [`SVFM_NPORT-1:0] vt_ports;

  function sel;
    input [`SVFM_ADDR_W-1:0] a;
    input [`SVFM_ADDR_W-1:0] off;
    begin
      sel = (a == off);
    end
  endfunction

  always @(posedge ref_clk) begin
    if (reset) begin
      uvid_reg <= `SVFM_UVID_RESET;
      mac0_reg <= `SVFM_MAC0_RESET;
      mac1_reg <= `SVFM_MAC1_RESET;
    end else if (reg_wr) begin
      if (sel(reg_addr, `SVFM_OFF_UVID)) begin
        uvid_reg <= reg_wdata & `SVFM_UVID_MASK;
      end
      if (sel(reg_addr, `SVFM_OFF_MAC0)) begin
        mac0_reg <= reg_wdata[7:0];
      end
      // No interlock with the alternate back-off bit: software keeps the pair consistent
      if (sel(reg_addr, `SVFM_OFF_MAC1)) begin
        mac1_reg <= reg_wdata[7:0];
      end
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped reads zero
  always @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (sel(reg_addr, `SVFM_OFF_UVID)) begin
        reg_rdata <= uvid_reg;
      end else if (sel(reg_addr, `SVFM_OFF_MAC0)) begin
        reg_rdata <= {24'h000000, mac0_reg};
      end else if (sel(reg_addr, `SVFM_OFF_MAC1)) begin
        reg_rdata <= {24'h000000, mac1_reg};
      end else if (sel(reg_addr, `SVFM_OFF_STAT)) begin
        reg_rdata <= {uvid_cnt_reg, drop_cnt_reg};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // VLAN lookup
  // ----------------------------------------
  svfm_vlan_table #(
    .VID_W(VID_W)
  ) u_vt (
    .ref_clk(ref_clk),
    .reset(reset),
    .wr_en(vt_wr_en),
    .wr_vid(vt_wr_vid),
    .wr_valid(vt_wr_valid),
    .wr_ports(vt_wr_ports),
    .rd_vid(frm_vid),
    .rd_hit(vt_hit),
    .rd_ports(vt_ports)
  );

  // ----------------------------------------
  // Frame classification and drop decision
  // ----------------------------------------
  reg is_fc_type;
  reg is_pause_da;
  reg fc_drop;
  reg len_drop;
  reg [1:0] cls_next;
  reg [`SVFM_NPORT-1:0] ports_next;

  always @* begin
    is_fc_type = (frm_type_len == `SVFM_TYPE_FC);
    is_pause_da = (frm_da == `SVFM_DA_PAUSE);
    if (mac0_reg[`SVFM_MAC0_FC_MODE]) begin
      fc_drop = is_fc_type | is_pause_da;
    end else begin
      fc_drop = is_fc_type & is_pause_da;
    end
    // Only a length field, not an EtherType, is checked
    len_drop = mac0_reg[`SVFM_MAC0_LEN_CHK] && (frm_type_len < `SVFM_LEN_LIMIT) &&
               (frm_type_len != frm_payload_len);
    // Unknown VID wins over unknown unicast and multicast
    if (!vt_hit) begin
      cls_next = CLS_UVID;
      ports_next = uvid_reg[`SVFM_UVID_EN] ? uvid_reg[`SVFM_NPORT-1:0] : {`SVFM_NPORT{1'b0}};
    end else if (frm_uucast) begin
      cls_next = CLS_UUC;
      ports_next = uucast_ports;
    end else if (frm_umcast) begin
      cls_next = CLS_UMC;
      ports_next = umcast_ports;
    end else begin
      cls_next = CLS_KNOWN;
      ports_next = vt_ports;
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      dec_valid <= 1'b0;
      dec_drop <= 1'b0;
      dec_ports <= {`SVFM_NPORT{1'b0}};
      dec_class <= CLS_KNOWN;
      drop_cnt_reg <= 16'h0000;
      uvid_cnt_reg <= 16'h0000;
    end else begin
      dec_valid <= frm_valid;
      if (frm_valid) begin
        dec_drop <= fc_drop | len_drop | (ports_next == {`SVFM_NPORT{1'b0}});
        dec_ports <= (fc_drop | len_drop) ? {`SVFM_NPORT{1'b0}} : ports_next;
        dec_class <= cls_next;
        if (fc_drop | len_drop) begin
          drop_cnt_reg <= drop_cnt_reg + 16'h0001;
        end
        if (cls_next == CLS_UVID) begin
          uvid_cnt_reg <= uvid_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // Per-port back-off and collision handling
  // ----------------------------------------
  genvar p;
  generate
    for (p = 0; p < `SVFM_NPORT; p = p + 1) begin : g_port
      always @(posedge ref_clk) begin
        if (reset) begin
          alt_backoff_en[p] <= 1'b0;
          agg_backoff_en[p] <= 1'b0;
          col_drop[p] <= 1'b0;
        end else begin
          // Full-duplex ports never see back-off, whatever the bits say
          alt_backoff_en[p] <= mac0_reg[`SVFM_MAC0_ALT_BO] & port_half_duplex[p];
          agg_backoff_en[p] <= mac0_reg[`SVFM_MAC0_AGG_BO] & port_half_duplex[p];
          col_drop[p] <= col_event[p] && (col_count >= `SVFM_XCOL_LIMIT) &&
                         !mac1_reg[`SVFM_MAC1_NO_XCOL];
        end
      end
    end
  endgenerate
endmodule // svfm_fwd_mac_ctrl

// ### svfm_fwd_mac_ctrl_asserts.sv
// Port assertions for the forwarding and MAC control block
`timescale 1ns/1ps
`include "svfm_consts.vh"
module svfm_chk (
  input wire ref_clk,
  input wire reset,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire frm_valid,
  input wire [47:0] frm_da,
  input wire [15:0] frm_type_len,
  input wire [2:0] col_event,
  input wire [4:0] col_count,
  input wire [2:0] port_half_duplex,
  input wire dec_valid,
  input wire dec_drop,
  input wire [2:0] dec_ports,
  input wire [1:0] dec_class,
  input wire [2:0] alt_backoff_en,
  input wire [2:0] agg_backoff_en,
  input wire [2:0] col_drop
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_dec_follows: assert property (frm_valid |=> dec_valid) else $error("no decision");
  a_dec_pulse: assert property (!frm_valid |=> !dec_valid) else $error("decision without frame");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("read data outside slot");
  a_fc_both: assert property (frm_valid && frm_type_len == `SVFM_TYPE_FC && frm_da == `SVFM_DA_PAUSE
    |=> dec_drop && dec_ports == 3'h0) else $error("pause frame kept");
  a_drop_ports: assert property (dec_valid |-> dec_drop == (dec_ports == 3'h0)) else $error("drop vs ports");
  a_class_hold: assert property (!frm_valid |=> $stable(dec_class) && $stable(dec_ports)) else $error("moved");
  a_alt_half: assert property ((alt_backoff_en & ~$past(port_half_duplex)) == 3'h0) else $error("alt full");
  a_agg_half: assert property ((agg_backoff_en & ~$past(port_half_duplex)) == 3'h0) else $error("agg full");
  a_col_quiet: assert property (col_event == 3'h0 |=> col_drop == 3'h0) else $error("stray col drop");
  a_col_under: assert property (col_count < `SVFM_XCOL_LIMIT |=> col_drop == 3'h0) else $error("early drop");
  cover property (dec_valid && dec_class == 2'h1);
  cover property (dec_valid && dec_class == 2'h3);
  cover property (col_drop != 3'h0);
endmodule // svfm_chk
bind svfm_fwd_mac_ctrl svfm_chk i_svfm_chk (
  .ref_clk(ref_clk),
  .reset(reset),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .frm_valid(frm_valid),
  .frm_da(frm_da),
  .frm_type_len(frm_type_len),
  .col_event(col_event),
  .col_count(col_count),
  .port_half_duplex(port_half_duplex),
  .dec_valid(dec_valid),
  .dec_drop(dec_drop),
  .dec_ports(dec_ports),
  .dec_class(dec_class),
  .alt_backoff_en(alt_backoff_en),
  .agg_backoff_en(agg_backoff_en),
  .col_drop(col_drop)
);

// ### svfm_link_partner.sv
// Link partner model: frame descriptors and collision events
`timescale 1ns/1ps
module svfm_link_partner (
  input wire ref_clk,
  output logic frm_valid,
  output logic [11:0] frm_vid,
  output logic [47:0] frm_da,
  output logic [15:0] frm_type_len,
  output logic [15:0] frm_payload_len,
  output logic frm_uucast,
  output logic frm_umcast,
  output logic [2:0] col_event,
  output logic [4:0] col_count
);
  initial {frm_valid, frm_vid, frm_da, frm_type_len, frm_payload_len, frm_uucast, frm_umcast, col_event, col_count} = '0;
  // Released fields are inverted so stale values cannot pass as valid
  task send(input [11:0] v, input [47:0] d, input [15:0] t, input [15:0] p, input [1:0] u);
    @(posedge ref_clk);
    {frm_valid, frm_vid, frm_da, frm_type_len, frm_payload_len, frm_uucast, frm_umcast} <= {1'b1, v, d, t, p, u};
    @(posedge ref_clk);
    {frm_valid, frm_vid, frm_da, frm_type_len, frm_payload_len, frm_uucast, frm_umcast} <= {1'b0, ~v, ~d, ~t, ~p, ~u};
  endtask
  task collide(input [2:0] e, input [4:0] n);
    @(posedge ref_clk);
    {col_event, col_count} <= {e, n};
    @(posedge ref_clk);
    {col_event, col_count} <= {3'h0, ~n};
  endtask
endmodule // svfm_link_partner

// ### svfm_tb.sv
// Self-checking bench for the forwarding and MAC control block
`timescale 1ns/1ps
`include "svfm_consts.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("unexpected %0t: got %h exp %h", $time, a, b); end end
module tb;
  localparam [47:0] DA = 48'h020000000001;
  localparam [15:0] TY = 16'h0800;
  logic ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, vt_wr_en = 1'b0, vt_wr_valid = 1'b0;
  logic [11:0] reg_addr = 12'h000, vt_wr_vid = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic [2:0] vt_wr_ports = 3'h0, uucast_ports = 3'h6, umcast_ports = 3'h5, port_half_duplex = 3'h0;
  wire [31:0] reg_rdata;
  wire [15:0] frm_type_len, frm_payload_len;
  wire [47:0] frm_da;
  wire [11:0] frm_vid;
  wire [4:0] col_count;
  wire [2:0] col_event, dec_ports, alt_backoff_en, agg_backoff_en, col_drop;
  wire [1:0] dec_class;
  wire frm_valid, frm_uucast, frm_umcast, dec_valid, dec_drop;
  int fails = 0, check_count = 0;
  logic dr;
  always #20 ref_clk = ~ref_clk;
  svfm_link_partner i_svfm_link_partner (.*);
  svfm_fwd_mac_ctrl i_svfm_fwd_mac_ctrl (.*);
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task wr(input [11:0] a, input [31:0] d);
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [11:0] a, input [31:0] e);
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  task fr(input [47:0] d, input [15:0] t, input [15:0] p, input [1:0] u, input [1:0] c, input e, input [2:0] q);
    i_svfm_link_partner.send(12'h005, d, t, p, u);
    #1 `CHK({dec_valid, dec_drop, dec_class, dec_ports}, {1'b1, e, c, q})
  endtask
  task results;
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #50000;
    fails++;
    results;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    rd(`SVFM_OFF_UVID, 32'h0);
    rd(`SVFM_OFF_MAC0, 32'h0000000e);
    rd(`SVFM_OFF_MAC1, 32'h0);
    rd(12'h400, 32'h0);
    wr(`SVFM_OFF_UVID, 32'hffffffff);
    rd(`SVFM_OFF_UVID, `SVFM_UVID_MASK);
    // Both unknown-DA flags set so the VID class must win
    for (int m = 0; m < 8; m++) begin
      wr(`SVFM_OFF_UVID, 32'h80000000 | m);
      fr(DA, TY, 16'h0, 2'b11, 2'h1, m == 0, m[2:0]);
    end
    wr(`SVFM_OFF_UVID, 32'h7);
    fr(DA, TY, 16'h0, 2'b00, 2'h1, 1'b1, 3'h0);
    @(posedge ref_clk);
    {vt_wr_en, vt_wr_vid, vt_wr_valid, vt_wr_ports} <= {1'b1, 12'h005, 1'b1, 3'h3};
    @(posedge ref_clk);
    vt_wr_en <= 1'b0;
    fr(DA, TY, 16'h0, 2'b00, 2'h0, 1'b0, 3'h3);
    fr(DA, TY, 16'h0, 2'b11, 2'h2, 1'b0, 3'h6);
    fr(DA, TY, 16'h0, 2'b01, 2'h3, 1'b0, 3'h5);
    for (int k = 0; k < 6; k++) begin
      if (k % 3 == 0) wr(`SVFM_OFF_MAC0, k ? 32'h0c : 32'h0e);
      dr = k < 3 || k % 3 == 2;
      fr(k % 3 ? `SVFM_DA_PAUSE : DA, k % 3 == 1 ? TY : `SVFM_TYPE_FC, 16'h0, 2'b00, 2'h0, dr, dr ? 3'h0 : 3'h3);
    end
    fr(DA, 16'h0064, 16'h0063, 2'b00, 2'h0, 1'b1, 3'h0);
    fr(DA, 16'h0064, 16'h0064, 2'b00, 2'h0, 1'b0, 3'h3);
    fr(DA, `SVFM_LEN_LIMIT, 16'h0, 2'b00, 2'h0, 1'b0, 3'h3);
    wr(`SVFM_OFF_MAC0, 32'h04);
    fr(DA, 16'h0064, 16'h0063, 2'b00, 2'h0, 1'b0, 3'h3);
    @(posedge ref_clk);
    port_half_duplex <= 3'h5;
    wr(`SVFM_OFF_MAC0, 32'h81);
    repeat (2) @(posedge ref_clk);
    #1 `CHK({alt_backoff_en, agg_backoff_en}, 6'h2d)
    @(posedge ref_clk);
    port_half_duplex <= 3'h2;
    wr(`SVFM_OFF_MAC0, 32'h80);
    repeat (2) @(posedge ref_clk);
    #1 `CHK({alt_backoff_en, agg_backoff_en}, 6'h10)
    rd(`SVFM_OFF_MAC0, 32'h80);
    i_svfm_link_partner.collide(3'h2, 5'h10);
    #1 `CHK(col_drop, 3'h2)
    i_svfm_link_partner.collide(3'h4, 5'h0f);
    #1 `CHK(col_drop, 3'h0)
    wr(`SVFM_OFF_MAC1, 32'h1);
    i_svfm_link_partner.collide(3'h1, 5'h1f);
    #1 `CHK(col_drop, 3'h0)
    // Nine unknown-VID frames and five filter drops were sent above
    rd(`SVFM_OFF_STAT, 32'h00090005);
    results;
  end
endmodule // tb
